// file: rtl/cs_ctrl.sv
// Controller end: feeds operands, decides the branch, keeps the
// reduced value. Assumes the sequencer end on the same clock.
`timescale 1ns/1ps
`include "cs_params.svh"
module cs_ctrl
    import cs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    cs_link_if.ctl           lnk,
    input  wire logic        go,
    input  wire logic [63:0] angle,
    output      logic        ready,
    output      logic [63:0] sine,
    output      logic        sine_valid
);
    // ========================================================
    // Coefficient table, highest order first
    localparam logic [63:0] COEF [0:8] = '{`CS_C8, `CS_C7, `CS_C6,
        `CS_C5, `CS_C4, `CS_C3, `CS_C2, `CS_C1, `CS_C0};

    cs_state_t   state_q, state_d;
    logic [63:0] angle_q, angle_d;
    logic [63:0] red_q, red_d;
    logic [63:0] sine_q, sine_d;
    logic        valid_q, valid_d;
    logic        start_q, start_d;
    logic        bv_q, bv_d;
    logic        bsub_q, bsub_d;
    logic [63:0] opnd;
    logic [5:0]  hoff;
    logic [5:0]  hidx;

    // ========================================================
    // Operand schedule; bus data follows the sequencer step
    // directly, so it carries no extra register delay.
    always_comb begin
        opnd = 64'h0;
        hoff = 6'(lnk.step - `CS_STEP_HORNER);
        hidx = 6'(6'h07 - 6'(hoff / 6'h03));
        case (lnk.step)
            6'h01: opnd = angle_q;
            6'h02: opnd = `CS_TWO_OVER_PI;
            6'h04: opnd = `CS_ONE;
            6'h05: opnd = `CS_QUARTER;
            6'h06: opnd = `CS_ONE;
            6'h08: opnd = `CS_FOUR_INT;
            6'h0d: opnd = bsub_q ? `CS_TWO : 64'h0;
            6'h0f: opnd = `CS_TWO;
            6'h12: opnd = `CS_NEG_ONE;
            6'h13: opnd = COEF[0];
            `CS_STEP_FINAL: opnd = red_q;
            default: begin
                if (lnk.step >= `CS_STEP_HORNER &&
                    lnk.step < `CS_STEP_FINAL && hoff % 6'h03 == 6'h00)
                    opnd = COEF[4'(6'h08 - hidx)];
            end
        endcase
    end

    assign lnk.first_operand_bus     = opnd[63:32];
    assign lnk.second_operand_bus    = opnd[31:0];
    assign lnk.pipeline_stage_select = `CS_STAGE_SEL;
    assign lnk.rounding_select =
        (lnk.step == `CS_STEP_TRUNC0 || lnk.step == `CS_STEP_TRUNC1)
        ? `CS_RND_TRUNCATE_OP : `CS_RND_NEAREST;
    assign lnk.start        = start_q;
    assign lnk.branch_valid = bv_q;
    assign lnk.branch_sub   = bsub_q;
    assign ready            = (state_q == CS_IDLE);
    assign sine             = sine_q;
    assign sine_valid       = valid_q;

    // ========================================================
    // Run control, branch decision and captures
    always_comb begin
        state_d = state_q;
        angle_d = angle_q;
        red_d   = red_q;
        sine_d  = sine_q;
        valid_d = 1'b0;
        start_d = 1'b0;
        bv_d    = bv_q;
        bsub_d  = bsub_q;
        case (state_q)
            CS_IDLE: begin
                if (go) begin
                    angle_d = angle;
                    start_d = 1'b1;
                    state_d = CS_RUN;
                end
            end
            CS_RUN: begin
                // Decide only once the compare flag stands
                if (lnk.step == `CS_STEP_WAIT && lnk.cmp_valid && !bv_q) begin
                    bv_d   = 1'b1;
                    bsub_d = lnk.cmp_gt;
                end
                if (lnk.step == `CS_STEP_BRANCH)
                    bv_d = 1'b0;
                if (lnk.result_valid && lnk.step == `CS_STEP_RED_HI)
                    red_d[63:32] = lnk.result_bus;
                if (lnk.result_valid && lnk.step == `CS_STEP_RED_LO)
                    red_d[31:0] = lnk.result_bus;
                if (lnk.result_valid && lnk.step == `CS_STEP_OUT_HI)
                    sine_d[63:32] = lnk.result_bus;
                if (lnk.result_valid && lnk.step == `CS_STEP_LAST) begin
                    sine_d[31:0] = lnk.result_bus;
                    state_d      = CS_DONE;
                end
            end
            CS_DONE: begin
                valid_d = 1'b1;
                state_d = CS_IDLE;
            end
            default: state_d = CS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= CS_IDLE;
            angle_q <= 64'h0;
            red_q   <= 64'h0;
            sine_q  <= 64'h0;
            valid_q <= 1'b0;
            start_q <= 1'b0;
            bv_q    <= 1'b0;
            bsub_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            angle_q <= angle_d;
            red_q   <= red_d;
            sine_q  <= sine_d;
            valid_q <= valid_d;
            start_q <= start_d;
            bv_q    <= bv_d;
            bsub_q  <= bsub_d;
        end
    end
endmodule

// file: rtl/cs_dev.sv
// Sequencer end: steps the sine schedule, holds the working
// registers and steers an external double-precision unit.
// Assumes the unit answers combinationally in the same cycle.
`timescale 1ns/1ps
`include "cs_params.svh"
module cs_dev
    import cs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    cs_link_if.dev           lnk,
    output      cs_op_t      fpu_op,
    output      logic [63:0] fpu_a,
    output      logic [63:0] fpu_b,
    output      logic [1:0]  fpu_rounding,
    output      logic [2:0]  fpu_stage,
    input  wire logic [63:0] fpu_res,
    input  wire logic        fpu_gt
);
    // ========================================================
    // Working registers
    logic [5:0]  step_q, step_d;
    logic [63:0] ra_q, ra_d;
    logic [63:0] rb_q, rb_d;
    logic [63:0] constant_hold_register_q, constant_hold_register_d;
    logic [63:0] work_q, work_d;
    logic [63:0] res_q, res_d;
    logic        cmpv_q, cmpv_d;
    logic        cmpg_q, cmpg_d;
    logic [31:0] out_q, out_d;
    logic        outv_q, outv_d;
    logic [63:0] bus;
    logic [5:0]  hoff;

    // Both halves of an operand arrive in the same step
    assign bus = {lnk.first_operand_bus, lnk.second_operand_bus};

    // Mode selects pass straight to the unit; truncation in
    // steps 6 and 7 relies on the controller
    assign fpu_rounding = lnk.rounding_select;
    assign fpu_stage    = lnk.pipeline_stage_select;

    assign lnk.step         = step_q;
    assign lnk.cmp_valid    = cmpv_q;
    assign lnk.cmp_gt       = cmpg_q;
    assign lnk.result_bus   = out_q;
    assign lnk.result_valid = outv_q;

    // ========================================================
    // Step counter; the wait step stalls for the decision, which
    // is where the extra budgeted cycles go.
    always_comb begin
        if (step_q == `CS_STEP_IDLE)
            step_d = lnk.start ? `CS_STEP_FIRST : `CS_STEP_IDLE;
        else if (step_q == `CS_STEP_WAIT)
            step_d = lnk.branch_valid ? `CS_STEP_BRANCH
                                      : `CS_STEP_WAIT;
        else if (step_q == `CS_STEP_LAST)
            step_d = `CS_STEP_IDLE;
        else
            step_d = 6'(step_q + 6'h01);
    end

    // ========================================================
    // Per-step instruction and operand routing
    always_comb begin
        ra_d   = ra_q;
        rb_d   = rb_q;
        constant_hold_register_d = constant_hold_register_q;
        work_d = work_q;
        res_d  = res_q;
        cmpv_d = cmpv_q;
        cmpg_d = cmpg_q;
        fpu_op = CS_OP_NOP;
        fpu_a  = 64'h0;
        fpu_b  = 64'h0;
        hoff   = 6'(step_q - `CS_STEP_HORNER);
        case (step_q)
            6'h01: ra_d = bus;
            6'h02: rb_d = bus;
            6'h03: begin
                fpu_op = CS_OP_MUL; // Angle times 2/pi
                fpu_a  = ra_q;
                fpu_b  = rb_q;
                work_d = fpu_res;
            end
            6'h04: rb_d = bus;
            6'h05: begin
                fpu_op = CS_OP_ADD; // Scaled value plus one
                fpu_a  = work_q;
                fpu_b  = rb_q;
                work_d = fpu_res;
                constant_hold_register_d = work_q;
                rb_d   = bus;
            end
            6'h06: begin
                fpu_op = CS_OP_MUL; // One quarter of the sum
                fpu_a  = work_q;
                fpu_b  = rb_q;
                work_d = fpu_res;
                ra_d   = bus;
            end
            6'h07: begin
                fpu_op = CS_OP_D2I; // Truncate to integer
                fpu_a  = work_q;
                work_d = fpu_res;
            end
            6'h08: begin
                fpu_op = CS_OP_IMUL; // Integer times four
                fpu_a  = work_q;
                fpu_b  = bus;
                work_d = fpu_res;
                rb_d   = bus;
            end
            6'h09: begin
                fpu_op = CS_OP_I2D; // Back to double
                fpu_a  = work_q;
                work_d = fpu_res;
            end
            6'h0a: begin
                fpu_op = CS_OP_SUB; // Hold minus multiple
                fpu_a  = constant_hold_register_q;
                fpu_b  = work_q;
                work_d = fpu_res;
            end
            6'h0b: begin
                fpu_op = CS_OP_CMP; // Compare 1.0 with value
                fpu_a  = ra_q;
                fpu_b  = work_q;
                constant_hold_register_d = work_q;
                cmpv_d = 1'b1;
                cmpg_d = fpu_gt;
            end
            6'h0d: begin
                cmpv_d = 1'b0;
                if (lnk.branch_sub) begin
                    fpu_op = CS_OP_SUB; // Two minus held value
                    fpu_a  = bus;
                    fpu_b  = constant_hold_register_q;
                    rb_d   = bus;
                end else begin
                    fpu_op = CS_OP_PASS; // Keep held value
                    fpu_a  = constant_hold_register_q;
                end
                constant_hold_register_d = fpu_res;
            end
            6'h0e: begin
                fpu_op = CS_OP_MUL; // Square
                fpu_a  = constant_hold_register_q;
                fpu_b  = constant_hold_register_q;
                work_d = fpu_res;
            end
            6'h0f: ra_d = bus;
            6'h10: begin
                fpu_op = CS_OP_MUL; // Doubled square
                fpu_a  = ra_q;
                fpu_b  = work_q;
                work_d = fpu_res;
            end
            6'h12: begin
                fpu_op = CS_OP_ADD; // Minus one, argument to hold
                fpu_a  = work_q;
                fpu_b  = bus;
                constant_hold_register_d = fpu_res;
                rb_d   = bus;
            end
            `CS_STEP_CORE: begin
                fpu_op = CS_OP_MUL; // Top coefficient times x
                fpu_a  = bus;
                fpu_b  = constant_hold_register_q;
                work_d = fpu_res;
                rb_d   = bus;
            end
            `CS_STEP_FINAL: begin
                fpu_op = CS_OP_MUL; // Core times reduced value
                fpu_a  = work_q;
                fpu_b  = bus;
                res_d  = fpu_res;
                rb_d   = bus;
            end
            6'h2c: begin
                // Dummy add gives the product time to settle
                fpu_op = CS_OP_ADD;
                fpu_a  = ra_q;
                fpu_b  = rb_q;
            end
            default: begin
                // Horner body: add coefficient, then multiply by x
                if (step_q >= `CS_STEP_HORNER &&
                    step_q < `CS_STEP_FINAL) begin
                    if (hoff % 6'h03 == 6'h00) begin
                        fpu_op = CS_OP_ADD;
                        fpu_a  = work_q;
                        fpu_b  = bus;
                        work_d = fpu_res;
                        rb_d   = bus;
                    end else if (hoff % 6'h03 == 6'h01 &&
                                 step_q <= `CS_STEP_LASTMUL) begin
                        fpu_op = CS_OP_MUL;
                        fpu_a  = work_q;
                        fpu_b  = constant_hold_register_q;
                        work_d = fpu_res;
                    end
                end
            end
        endcase
    end

    // ========================================================
    // Result bus; registered from next-cycle values so halves
    // stand exactly in their own steps.
    always_comb begin
        out_d  = 32'h0;
        outv_d = 1'b0;
        case (step_d)
            `CS_STEP_RED_HI: begin
                out_d  = constant_hold_register_d[63:32];
                outv_d = 1'b1;
            end
            `CS_STEP_RED_LO: begin
                out_d  = constant_hold_register_d[31:0];
                outv_d = 1'b1;
            end
            `CS_STEP_OUT_HI: begin
                out_d  = res_d[63:32];
                outv_d = 1'b1;
            end
            `CS_STEP_LAST: begin
                out_d  = res_d[31:0];
                outv_d = 1'b1;
            end
            default: begin
                out_d  = 32'h0;
                outv_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_q <= `CS_STEP_IDLE;
            ra_q   <= 64'h0;
            rb_q   <= 64'h0;
            constant_hold_register_q <= 64'h0;
            work_q <= 64'h0;
            res_q  <= 64'h0;
            cmpv_q <= 1'b0;
            cmpg_q <= 1'b0;
            out_q  <= 32'h0;
            outv_q <= 1'b0;
        end else begin
            step_q <= step_d;
            ra_q   <= ra_d;
            rb_q   <= rb_d;
            constant_hold_register_q <= constant_hold_register_d;
            work_q <= work_d;
            res_q  <= res_d;
            cmpv_q <= cmpv_d;
            cmpg_q <= cmpg_d;
            out_q  <= out_d;
            outv_q <= outv_d;
        end
    end
endmodule

// file: rtl/cs_link_if.sv
// Link between the controller and the sine sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cs_link_if (
    input logic clk
);
    logic        start;
    logic [31:0] first_operand_bus;
    logic [31:0] second_operand_bus;
    logic [2:0]  pipeline_stage_select;
    logic [1:0]  rounding_select;
    logic        branch_valid;
    logic        branch_sub;
    logic [5:0]  step;
    logic        cmp_valid;
    logic        cmp_gt;
    logic [31:0] result_bus;
    logic        result_valid;

    modport dev (
        input  start, first_operand_bus, second_operand_bus,
        input  pipeline_stage_select, rounding_select,
        input  branch_valid, branch_sub,
        output step, cmp_valid, cmp_gt, result_bus, result_valid
    );
    modport ctl (
        output start, first_operand_bus, second_operand_bus,
        output pipeline_stage_select, rounding_select,
        output branch_valid, branch_sub,
        input  step, cmp_valid, cmp_gt, result_bus, result_valid
    );
endinterface

// file: rtl/cs_params.svh
// Constants shared by both ends of the sine sequencer link.
// Assumes one 125 MHz clock and operands split into 32-bit halves.
// Function
// - Doubles except the integer multiple in steps 7-9, angle given in radians
// - Scale by 2/pi, remove four-period multiple
// - Argument is twice square minus one
// - Horner evaluation of nine coefficients
// - Sine equals core output times reduced value
// - Controller stores and re-supplies reduced value
// - Stage select 010, rounding 00
// - Controller forces truncation in steps 6-7
// - Times four, to double, subtract from hold
// - Step 11 compares, step 12 waits
// - Controller picks subtract-from-two or pass
// - Reduced value on result bus, steps 14-15
// - Upper half first bus, lower second
// - 46 schedule steps, 51 budgeted
// - Coefficients are fixed double bit patterns
// - Final result upper then lower, 45-46
`ifndef CS_PARAMS_SVH
`define CS_PARAMS_SVH

// ============================================================
// Schedule steps
`define CS_STEP_IDLE     6'h00
`define CS_STEP_FIRST    6'h01
`define CS_STEP_TRUNC0   6'h06
`define CS_STEP_TRUNC1   6'h07
`define CS_STEP_CMP      6'h0b
`define CS_STEP_WAIT     6'h0c
`define CS_STEP_BRANCH   6'h0d
`define CS_STEP_RED_HI   6'h0e
`define CS_STEP_RED_LO   6'h0f
`define CS_STEP_CORE     6'h13
`define CS_STEP_HORNER   6'h15
`define CS_STEP_LASTMUL  6'h28
`define CS_STEP_FINAL    6'h2b
`define CS_STEP_OUT_HI   6'h2d
`define CS_STEP_LAST     6'h2e
`define CS_STEP_BUDGET   51

// ============================================================
// Mode selects
`define CS_STAGE_SEL     3'h2
`define CS_RND_NEAREST   2'h0
`define CS_RND_TRUNCATE_OP     2'h1

// ============================================================
// Operand constants
`define CS_TWO_OVER_PI   64'h3fe45f306dc9c883
`define CS_ONE           64'h3ff0000000000000
`define CS_QUARTER       64'h3fd0000000000000
`define CS_FOUR_INT      64'h0000000000000004
`define CS_TWO           64'h4000000000000000
`define CS_NEG_ONE       64'hbff0000000000000
`define CS_C8            64'h3d19d46b7d4c8f32
`define CS_C7            64'hbd962909c5c01ed6
`define CS_C6            64'h3e0d53517735f927
`define CS_C5            64'hbe7cc930fd0ada9d
`define CS_C4            64'h3ee3e0af61f7677f
`define CS_C3            64'hbf41e5fdef25c403
`define CS_C2            64'h3f92a9fb40c119ed
`define CS_C1            64'hbfd23b03366aa0c9
`define CS_C0            64'h3ff4464bcc8cba1f

`endif

// file: rtl/cs_pkg.sv
// Types shared by the sine sequencer ends.
// Assumes cs_params.svh for the numeric constants.
package cs_pkg;
    // ========================================================
    // Operations issued to the arithmetic unit
    typedef enum logic [3:0] {
        CS_OP_NOP  = 4'h0,
        CS_OP_MUL  = 4'h1,
        CS_OP_ADD  = 4'h2,
        CS_OP_SUB  = 4'h3,
        CS_OP_D2I  = 4'h4,
        CS_OP_IMUL = 4'h5,
        CS_OP_I2D  = 4'h6,
        CS_OP_CMP  = 4'h7,
        CS_OP_PASS = 4'h8
    } cs_op_t;

    // ========================================================
    // Controller states
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_RUN  = 2'b01,
        CS_DONE = 2'b10
    } cs_state_t;
endpackage

// file: tb/chebyshev_sine_sequencer_bench.sv
// Bench joining controller and sequencer, with a real-valued unit.
// Assumes cs_params.svh constants; unit ops taken as a op b.
`timescale 1ns/1ps
`include "cs_params.svh"
module chebyshev_sine_sequencer_bench
    import cs_pkg::*;
();
    logic        clk;
    logic        rst;
    logic        go;
    logic [63:0] angle;
    logic        ready;
    logic [63:0] sine;
    logic        sine_valid;
    cs_op_t      fpu_op;
    logic [63:0] fpu_a;
    logic [63:0] fpu_b;
    logic [1:0]  fpu_rounding;
    logic [2:0]  fpu_stage;
    logic [63:0] fpu_res;
    logic        fpu_gt;
    logic [15:0] lfsr;
    real         ra;
    real         rb;
    int          fail_count;
    int          comparisons;
    localparam logic [63:0] COEF [9] = '{`CS_C8, `CS_C7, `CS_C6,
        `CS_C5, `CS_C4, `CS_C3, `CS_C2, `CS_C1, `CS_C0};

    cs_link_if lnk (.clk(clk));
    cs_ctrl u_cs_ctrl (.clk(clk), .rst(rst), .lnk(lnk), .go(go),
        .angle(angle), .ready(ready), .sine(sine),
        .sine_valid(sine_valid));
    cs_dev u_cs_dev (.clk(clk), .rst(rst), .lnk(lnk), .fpu_op(fpu_op),
        .fpu_a(fpu_a), .fpu_b(fpu_b), .fpu_rounding(fpu_rounding),
        .fpu_stage(fpu_stage), .fpu_res(fpu_res), .fpu_gt(fpu_gt));
    cs_link_props u_props (.clk(clk), .rst(rst), .start(lnk.start),
        .first_operand_bus(lnk.first_operand_bus),
        .second_operand_bus(lnk.second_operand_bus),
        .pipeline_stage_select(lnk.pipeline_stage_select),
        .rounding_select(lnk.rounding_select),
        .branch_valid(lnk.branch_valid), .branch_sub(lnk.branch_sub),
        .step(lnk.step), .cmp_valid(lnk.cmp_valid), .cmp_gt(lnk.cmp_gt),
        .result_bus(lnk.result_bus), .result_valid(lnk.result_valid));

    // ==========================================================
    // Arithmetic unit, answering in the same cycle
    always_comb begin
        ra = $bitstoreal(fpu_a);
        rb = $bitstoreal(fpu_b);
        fpu_gt = rb > ra;
        case (fpu_op)
            CS_OP_MUL:  fpu_res = $realtobits(ra * rb);
            CS_OP_ADD:  fpu_res = $realtobits(ra + rb);
            CS_OP_SUB:  fpu_res = $realtobits(ra - rb);
            CS_OP_D2I:  fpu_res = (fpu_rounding == `CS_RND_TRUNCATE_OP) ?
                64'(longint'($rtoi(ra))) : 64'(longint'(ra));
            CS_OP_IMUL: fpu_res = fpu_a * fpu_b;
            CS_OP_I2D:  fpu_res = $realtobits(real'($signed(fpu_a)));
            CS_OP_PASS: fpu_res = fpu_a;
            default:    fpu_res = 64'h0;
        endcase
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // Reference model and helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic model(input real x, output logic [63:0] red,
                         output logic [63:0] sn, output logic gt);
        real    x1;
        real    x2;
        real    x4;
        real    x5;
        longint t;
        x1 = x * $bitstoreal(`CS_TWO_OVER_PI);
        t = 4 * $rtoi(0.25 * (x1 + 1.0));
        x2 = x1 - real'(t);
        gt = x2 > 1.0;
        if (gt) begin
            x2 = 2.0 - x2;
        end
        x4 = x2 * x2 * 2.0 - 1.0;
        x5 = $bitstoreal(COEF[0]);
        for (int i = 1; i < 9; i++) begin
            x5 = x5 * x4 + $bitstoreal(COEF[i]);
        end
        red = $realtobits(x2);
        sn = $realtobits(x5 * x2);
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_step(input logic [5:0] s);
        for (int n = 0; n < 80 && lnk.step !== s; n++) @(negedge clk);
        check({58'h0, lnk.step}, {58'h0, s});
    endtask

    // Go is offered again mid-run with a junk angle; it must be ignored
    task automatic run(input real x);
        logic [63:0] red;
        logic [63:0] sn;
        logic        gt;
        real         d;
        model(x, red, sn, gt);
        for (int n = 0; n < 80 && ready !== 1'b1; n++) @(negedge clk);
        go = 1'b1;
        angle = $realtobits(x);
        @(negedge clk);
        go = 1'b0;
        wait_step(`CS_STEP_WAIT);
        check({63'h0, lnk.cmp_gt}, {63'h0, gt});
        check({61'h0, fpu_stage}, {61'h0, `CS_STAGE_SEL});
        wait_step(`CS_STEP_RED_HI);
        check({32'h0, lnk.result_bus}, {32'h0, red[63:32]});
        lfsr = lfsr_next(lfsr);
        go = 1'b1;
        angle = {lfsr, lfsr, lfsr, lfsr};
        @(negedge clk);
        go = 1'b0;
        check({32'h0, lnk.result_bus}, {32'h0, red[31:0]});
        for (int n = 0; n < 60 && sine_valid !== 1'b1; n++) @(negedge clk);
        check(sine, sn);
        d = $bitstoreal(sine) - $sin(x);
        if (x >= 0.0) begin
            check({63'h0, d < 1.0e-9 && d > -1.0e-9}, 64'h1);
        end
        $display("test done angle %f", x);
    endtask

    task automatic close_out;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(8 * 5000);
        fail_count++;
        close_out();
    end

    // ==========================================================
    // Main sequence: both branch paths, zero, negative, random
    initial begin
        rst = 1'b1;
        go = 1'b0;
        angle = 64'h0;
        lfsr = 16'h001d;
        fail_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        run(0.5);
        run(3.0);
        run(0.0);
        run(-2.0);
        for (int k = 0; k < 6; k++) begin
            run(real'(lfsr % 16'h03e8) / 100.0);
        end
        // Reset in mid-run must return both ends to idle
        go = 1'b1;
        angle = $realtobits(1.0);
        @(negedge clk);
        go = 1'b0;
        repeat (20) @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        check({58'h0, lnk.step}, 64'h0);
        check({63'h0, ready}, 64'h1);
        run(1.0);
        close_out();
    end
endmodule

// file: tb/cs_link_props.sv
// Concurrent checks on the link between the two ends.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`include "cs_params.svh"
module cs_link_props (
    input logic        clk,
    input logic        rst,
    input logic        start,
    input logic [31:0] first_operand_bus,
    input logic [31:0] second_operand_bus,
    input logic [2:0]  pipeline_stage_select,
    input logic [1:0]  rounding_select,
    input logic        branch_valid,
    input logic        branch_sub,
    input logic [5:0]  step,
    input logic        cmp_valid,
    input logic        cmp_gt,
    input logic [31:0] result_bus,
    input logic        result_valid
);
    // ==========================================================
    // Reduced value as it left on the result bus
    logic [63:0] red_q;
    logic [63:0] red_d;
    logic [63:0] ops;
    assign ops = {first_operand_bus, second_operand_bus};
    always_comb begin
        red_d = red_q;
        if (result_valid && step == `CS_STEP_RED_HI) begin
            red_d[63:32] = result_bus;
        end
        if (result_valid && step == `CS_STEP_RED_LO) begin
            red_d[31:0] = result_bus;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            red_q <= 64'h0;
        end else begin
            red_q <= red_d;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence red_out;
        step == `CS_STEP_RED_HI && result_valid ##1
        step == `CS_STEP_RED_LO && result_valid;
    endsequence
    sequence sine_out;
        step == `CS_STEP_OUT_HI && result_valid ##1
        step == `CS_STEP_LAST && result_valid;
    endsequence
    a_stage_fixed: assert property (
        pipeline_stage_select == `CS_STAGE_SEL)
        else $error("stage select not fixed");
    a_round_truncate_op: assert property (
        rounding_select == ((step == 6'h06 || step == 6'h07) ?
            `CS_RND_TRUNCATE_OP : `CS_RND_NEAREST))
        else $error("rounding select wrong for step");
    a_start_first: assert property (
        step == `CS_STEP_IDLE && start |=> step == `CS_STEP_FIRST)
        else $error("start did not begin a run");
    a_step_advance: assert property (
        step != `CS_STEP_IDLE && step != `CS_STEP_WAIT &&
        step != `CS_STEP_LAST |=> step == $past(step) + 6'h01)
        else $error("step did not advance by one");
    a_last_idle: assert property (
        step == `CS_STEP_LAST |=> step == `CS_STEP_IDLE)
        else $error("run did not end after last step");
    a_cmp_ready: assert property (
        step == `CS_STEP_CMP |=> step == `CS_STEP_WAIT && cmp_valid)
        else $error("compare result not offered");
    a_wait_hold: assert property (
        step == `CS_STEP_WAIT && !branch_valid |=> step == `CS_STEP_WAIT)
        else $error("left wait step without a decision");
    a_wait_bound: assert property (
        $rose(cmp_valid) |-> ##[1:5] step == `CS_STEP_BRANCH)
        else $error("branch not taken within budget");
    a_branch_match: assert property (
        branch_valid |-> branch_sub == cmp_gt)
        else $error("branch decision disagrees with compare");
    a_two_bus: assert property (
        step == `CS_STEP_BRANCH && branch_sub |-> ops == `CS_TWO)
        else $error("2.0 missing on subtract path");
    a_red_pair: assert property (
        step == `CS_STEP_BRANCH |=> red_out)
        else $error("reduced value halves not output");
    a_sine_pair: assert property (
        step == 6'h2c |=> sine_out)
        else $error("result halves not output");
    a_two_over_pi: assert property (
        step == 6'h02 |-> ops == `CS_TWO_OVER_PI)
        else $error("scale constant missing");
    a_coef_ends: assert property (
        step == `CS_STEP_CORE || step == 6'h2a |->
        ops == ((step == `CS_STEP_CORE) ? `CS_C8 : `CS_C0))
        else $error("end coefficient wrong");
    a_red_back: assert property (
        step == `CS_STEP_FINAL |-> ops == red_q)
        else $error("reduced value not supplied back");
endmodule
